//--- mipc_pkg.sv
package mipc_pkg;

  // Register byte addresses
  localparam logic [7:0] MIPC_OFF_CTRL_ONE = 8'h20;
  localparam logic [7:0] MIPC_OFF_CTRL_TWO = 8'h40;
  localparam logic [7:0] MIPC_OFF_STATUS   = 8'h60;
  localparam logic [7:0] MIPC_OFF_CLEAR    = 8'h64;
  localparam logic [7:0] MIPC_OFF_ENABLE   = 8'h68;

  localparam logic [7:0] MIPC_CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] MIPC_CTRL_TWO_RST = 8'h00;
  localparam logic [5:0] MIPC_EVT_RST      = 6'h00;

  // Field positions
  localparam int MIPC_SENSE_A_LSB = 6;
  localparam int MIPC_SENSE_B_LSB = 4;
  localparam int MIPC_NMI_EDGE    = 1;
  localparam int MIPC_NMI_EN      = 0;
  localparam int MIPC_EVT_NMI     = 5;

  // Pin groups of the 32-bit pin vector (one 3:0, two 7:4, three 14:8, four 23:16, five 31:24)
  localparam logic [31:0] MIPC_GRP_ONE   = 32'h0000000F;
  localparam logic [31:0] MIPC_GRP_TWO   = 32'h000000F0;
  localparam logic [31:0] MIPC_GRP_THREE = 32'h00007F00;
  localparam logic [31:0] MIPC_GRP_FOUR  = 32'h00FF0000;
  localparam logic [31:0] MIPC_GRP_FIVE  = 32'hFF000000;

  // Beep timing
  localparam longint MIPC_CLK_HZ     = 50000000;
  localparam longint MIPC_BEEP_2K_HZ = 2000;
  localparam longint MIPC_BEEP_1K_HZ = 1000;
  localparam longint MIPC_BEEP_500_HZ = 500;
  localparam int MIPC_BEEP_2K_HALF  = int'(MIPC_CLK_HZ / (2 * MIPC_BEEP_2K_HZ));
  localparam int MIPC_BEEP_1K_HALF  = int'(MIPC_CLK_HZ / (2 * MIPC_BEEP_1K_HZ));
  localparam int MIPC_BEEP_500_HALF = int'(MIPC_CLK_HZ / (2 * MIPC_BEEP_500_HZ));

  typedef enum logic [1:0] {
    MIPC_SENSE_FALL_LOW = 2'b00,
    MIPC_SENSE_FALL     = 2'b01,
    MIPC_SENSE_RISE     = 2'b10,
    MIPC_SENSE_BOTH     = 2'b11
  } mipc_sense_t;

  typedef struct packed {
    mipc_sense_t sense_a;
    mipc_sense_t sense_b;
    logic [1:0]  rsvd;
    logic        nonmask_edge_sel;
    logic        nonmask_enable;
  } mipc_ctrl_one_t;

  typedef struct packed {
    logic       aux_clock_out_en;
    logic       main_clock_out_en;
    logic [1:0] beep_sel;
    logic [1:0] rsvd;
    logic       slave_select_source;
    logic       slave_select_internal;
  } mipc_ctrl_two_t;

endpackage

//--- mipc_top.sv
`timescale 1ns/1ps
module mipc_top
  import mipc_pkg::*;
#(
  parameter int BEEP_2K_HALF  = MIPC_BEEP_2K_HALF,
  parameter int BEEP_1K_HALF  = MIPC_BEEP_1K_HALF,
  parameter int BEEP_500_HALF = MIPC_BEEP_500_HALF
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [1:0]  irq_level_in,
  input  wire logic        halt_mode_in,
  input  wire logic [31:0] pin_in,
  input  wire logic [31:0] pin_dir_in,
  input  wire logic [31:0] pin_opt_in,
  input  wire logic        nonmask_pin_in,
  input  wire logic        aux_osc_in,
  input  wire logic        ss_n_pin_in,
  output logic [4:0]       ext_irq_out,
  output logic             nonmask_irq_out,
  output logic             spi_ss_n_out,
  output logic             beep_pin_out,
  output logic             beep_pin_oe_out,
  output logic             aux_clock_pin_out,
  output logic             aux_clock_pin_oe_out,
  output logic             irq_out
);

  mipc_ctrl_one_t ctrl_one_q;
  mipc_ctrl_two_t ctrl_two_q;
  logic [5:0]     status_q;
  logic [5:0]     enable_q;
  logic [31:0]    prdata_q;

  // APB decode
  logic acc_wr;
  logic setup_rd;
  logic addr_ok;
  logic top_level;
  assign addr_ok  = (paddr_in == MIPC_OFF_CTRL_ONE) || (paddr_in == MIPC_OFF_CTRL_TWO) ||
                    (paddr_in == MIPC_OFF_STATUS) || (paddr_in == MIPC_OFF_CLEAR) ||
                    (paddr_in == MIPC_OFF_ENABLE);
  assign acc_wr   = psel_in && penable_in && pwrite_in;
  assign setup_rd = psel_in && !penable_in && !pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;
  assign prdata_out  = prdata_q;
  assign top_level   = (irq_level_in == 2'b11);

  // Control one
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl_one_q <= mipc_ctrl_one_t'(MIPC_CTRL_ONE_RST);
    end else if (acc_wr && paddr_in == MIPC_OFF_CTRL_ONE) begin
      if (top_level) begin
        ctrl_one_q.sense_a <= mipc_sense_t'(pwdata_in[MIPC_SENSE_A_LSB +: 2]);
        ctrl_one_q.sense_b <= mipc_sense_t'(pwdata_in[MIPC_SENSE_B_LSB +: 2]);
      end
      if (!ctrl_one_q.nonmask_enable) begin
        ctrl_one_q.nonmask_edge_sel <= pwdata_in[MIPC_NMI_EDGE];
      end
      ctrl_one_q.nonmask_enable <= pwdata_in[MIPC_NMI_EN];
      ctrl_one_q.rsvd           <= 2'h0;
    end
  end

  // Control two
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl_two_q <= mipc_ctrl_two_t'(MIPC_CTRL_TWO_RST);
    end else if (acc_wr && paddr_in == MIPC_OFF_CTRL_TWO) begin
      ctrl_two_q      <= mipc_ctrl_two_t'(pwdata_in[7:0]);
      ctrl_two_q.rsvd <= 2'h0;
    end
  end

  // Read data latched in setup so it stands through the access phase
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      prdata_q <= 32'h00000000;
    end else if (setup_rd) begin
      unique case (paddr_in)
        MIPC_OFF_CTRL_ONE: prdata_q <= {24'h000000, ctrl_one_q};
        MIPC_OFF_CTRL_TWO: prdata_q <= {24'h000000, ctrl_two_q};
        MIPC_OFF_STATUS:   prdata_q <= {26'h0000000, status_q};
        MIPC_OFF_ENABLE:   prdata_q <= {26'h0000000, enable_q};
        default:           prdata_q <= 32'h00000000;
      endcase
    end
  end

  // Pin synchronisers: pins, nonmask, aux osc, slave select
  logic [34:0] sync1_q;
  logic [34:0] sync2_q;
  logic [34:0] sync3_q;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sync1_q <= {35{1'b1}};
      sync2_q <= {35{1'b1}};
      sync3_q <= {35{1'b1}};
    end else begin
      sync1_q <= {ss_n_pin_in, aux_osc_in, nonmask_pin_in, pin_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Per-pin trigger
  logic [31:0] pin_req;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_pin
      mipc_sense_t mode;
      logic        fall;
      logic        rise;
      if ((gi >= 4 && gi < 8) || (gi >= 16 && gi < 24)) begin : g_b
        assign mode = ctrl_one_q.sense_b;
      end else begin : g_a
        assign mode = ctrl_one_q.sense_a;
      end
      assign fall = sync3_q[gi] && !sync2_q[gi];
      assign rise = !sync3_q[gi] && sync2_q[gi];
      assign pin_req[gi] = !pin_dir_in[gi] && pin_opt_in[gi] &&
        ((fall && mode != MIPC_SENSE_RISE) || (rise && mode[1]) ||
         (!sync2_q[gi] && mode == MIPC_SENSE_FALL_LOW));
    end
  endgenerate

  logic [4:0] grp_req;
  assign grp_req = {|(pin_req & MIPC_GRP_FIVE), |(pin_req & MIPC_GRP_FOUR),
                    |(pin_req & MIPC_GRP_THREE), |(pin_req & MIPC_GRP_TWO),
                    |(pin_req & MIPC_GRP_ONE)};

  logic nmi_req;
  assign nmi_req = ctrl_one_q.nonmask_enable &&
    (ctrl_one_q.nonmask_edge_sel ? (!sync3_q[32] && sync2_q[32])
                                 : (sync3_q[32] && !sync2_q[32]));

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ext_irq_out     <= 5'h00;
      nonmask_irq_out <= 1'b0;
    end else begin
      ext_irq_out     <= grp_req;
      nonmask_irq_out <= nmi_req;
    end
  end

  // Sticky status, set beats clear
  logic [5:0] evt;
  assign evt = {nmi_req, grp_req};
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      status_q <= MIPC_EVT_RST;
    end else if (acc_wr && paddr_in == MIPC_OFF_CLEAR) begin
      status_q <= (status_q & ~pwdata_in[5:0]) | evt;
    end else begin
      status_q <= status_q | evt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      enable_q <= MIPC_EVT_RST;
    end else if (acc_wr && paddr_in == MIPC_OFF_ENABLE) begin
      enable_q <= pwdata_in[5:0];
    end
  end

  assign irq_out = |(status_q & enable_q);

  // Slave select
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      spi_ss_n_out <= 1'b1;
    end else if (ctrl_two_q.slave_select_source) begin
      spi_ss_n_out <= ctrl_two_q.slave_select_internal;
    end else begin
      spi_ss_n_out <= sync2_q[34];
    end
  end

  // Clock dividers and beep tone
  logic        main_div_q;
  logic        aux_div_q;
  logic        beep_q;
  logic [15:0] beep_cnt_q;
  logic [15:0] beep_lim;
  always_comb begin
    unique case (ctrl_two_q.beep_sel)
      2'b01:   beep_lim = 16'(BEEP_2K_HALF - 1);
      2'b10:   beep_lim = 16'(BEEP_1K_HALF - 1);
      2'b11:   beep_lim = 16'(BEEP_500_HALF - 1);
      default: beep_lim = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || halt_mode_in) begin
      main_div_q <= 1'b0;
      aux_div_q  <= 1'b0;
    end else begin
      main_div_q <= !main_div_q;
      if (!sync3_q[33] && sync2_q[33]) begin
        aux_div_q <= !aux_div_q;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || halt_mode_in || ctrl_two_q.beep_sel == 2'b00) begin
      beep_cnt_q <= 16'h0000;
      beep_q     <= 1'b0;
    end else if (beep_cnt_q >= beep_lim) begin
      beep_cnt_q <= 16'h0000;
      beep_q     <= !beep_q;
    end else begin
      beep_cnt_q <= beep_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      beep_pin_out         <= 1'b0;
      beep_pin_oe_out      <= 1'b0;
      aux_clock_pin_out    <= 1'b0;
      aux_clock_pin_oe_out <= 1'b0;
    end else begin
      aux_clock_pin_oe_out <= ctrl_two_q.aux_clock_out_en && !halt_mode_in;
      aux_clock_pin_out    <= aux_div_q;
      if (halt_mode_in) begin
        beep_pin_oe_out <= 1'b0;
        beep_pin_out    <= 1'b0;
      end else if (ctrl_two_q.beep_sel != 2'b00) begin
        beep_pin_oe_out <= 1'b1;
        beep_pin_out    <= beep_q;
      end else begin
        beep_pin_oe_out <= ctrl_two_q.main_clock_out_en;
        beep_pin_out    <= main_div_q;
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_sense_locked: assert property (
    (acc_wr && paddr_in == MIPC_OFF_CTRL_ONE && !top_level) |=>
      $stable({ctrl_one_q.sense_a, ctrl_one_q.sense_b}))
    else $error("sense field changed below top priority");
  a_sense_write: assert property (
    (acc_wr && paddr_in == MIPC_OFF_CTRL_ONE && top_level) |=>
      ctrl_one_q.sense_a == $past(pwdata_in[7:6]) && ctrl_one_q.sense_b == $past(pwdata_in[5:4]))
    else $error("sense field not written");
  a_low_pri_en: assert property (
    (acc_wr && paddr_in == MIPC_OFF_CTRL_ONE) |=>
      ctrl_one_q.nonmask_enable == $past(pwdata_in[0]))
    else $error("enable bit not written");
  a_edge_locked: assert property (
    (acc_wr && paddr_in == MIPC_OFF_CTRL_ONE && ctrl_one_q.nonmask_enable) |=>
      $stable(ctrl_one_q.nonmask_edge_sel))
    else $error("edge select changed while enabled");
  a_rsvd_zero: assert property (
    ctrl_one_q.rsvd == 2'h0 && ctrl_two_q.rsvd == 2'h0)
    else $error("reserved bits nonzero");
  a_nmi_off: assert property (
    !ctrl_one_q.nonmask_enable |=> !nonmask_irq_out)
    else $error("nonmask irq while disabled");
  a_halt_quiet: assert property (
    halt_mode_in |=> !beep_pin_oe_out && !aux_clock_pin_oe_out)
    else $error("clock out active in halt");
  a_ss_internal: assert property (
    ctrl_two_q.slave_select_source |=> spi_ss_n_out == $past(ctrl_two_q.slave_select_internal))
    else $error("slave select not from internal bit");
  a_pin_gated: assert property (
    ((pin_dir_in | ~pin_opt_in) == 32'hFFFFFFFF) |-> grp_req == 5'h00)
    else $error("gated pin raised interrupt");
  a_beep_period: assert property (
    (!halt_mode_in && ctrl_two_q.beep_sel != 2'b00 && $changed(beep_q)) |=>
      !$changed(beep_q) [*2])
    else $error("beep toggles too fast");

  // Register holding and nonmaskable edge handling
  a_sense_hold: assert property (
    !(acc_wr && paddr_in == MIPC_OFF_CTRL_ONE) |=>
      $stable({ctrl_one_q.sense_a, ctrl_one_q.sense_b}))
    else $error("sense field changed without a write");
  a_edge_write: assert property (
    (acc_wr && paddr_in == MIPC_OFF_CTRL_ONE && !ctrl_one_q.nonmask_enable) |=>
      ctrl_one_q.nonmask_edge_sel == $past(pwdata_in[MIPC_NMI_EDGE]))
    else $error("edge select not written while disabled");
  a_nmi_rise: assert property (
    (ctrl_one_q.nonmask_enable && ctrl_one_q.nonmask_edge_sel &&
     !sync3_q[32] && sync2_q[32]) |=> nonmask_irq_out)
    else $error("rising nonmask edge missed");
  a_nmi_fall: assert property (
    (ctrl_one_q.nonmask_enable && !ctrl_one_q.nonmask_edge_sel &&
     sync3_q[32] && !sync2_q[32]) |=> nonmask_irq_out)
    else $error("falling nonmask edge missed");

  // Pin interrupt mapping
  a_level_req: assert property (
    (ctrl_one_q.sense_a == MIPC_SENSE_FALL_LOW && !sync2_q[0] &&
     !pin_dir_in[0] && pin_opt_in[0]) |=> ext_irq_out[0])
    else $error("low level request missed");
  a_group_a_map: assert property (
    (ctrl_one_q.sense_a == MIPC_SENSE_BOTH && sync3_q[24] != sync2_q[24] &&
     !pin_dir_in[24] && pin_opt_in[24]) |=> ext_irq_out[4])
    else $error("group five edge missed");
  a_group_b_map: assert property (
    (ctrl_one_q.sense_b == MIPC_SENSE_BOTH && sync3_q[16] != sync2_q[16] &&
     !pin_dir_in[16] && pin_opt_in[16]) |=> ext_irq_out[3])
    else $error("group four edge missed");

  // Pin functions of control two
  a_aux_drive: assert property (
    (ctrl_two_q.aux_clock_out_en && !halt_mode_in) |=>
      aux_clock_pin_oe_out && aux_clock_pin_out == $past(aux_div_q))
    else $error("aux clock not driven");
  a_aux_idle: assert property (
    !ctrl_two_q.aux_clock_out_en |=> !aux_clock_pin_oe_out)
    else $error("aux pin driven while off");
  a_port_idle: assert property (
    (!ctrl_two_q.main_clock_out_en && ctrl_two_q.beep_sel == 2'b00) |=> !beep_pin_oe_out)
    else $error("beep pin driven while off");
  a_main_clock: assert property (
    (!halt_mode_in && ctrl_two_q.main_clock_out_en && ctrl_two_q.beep_sel == 2'b00) |=>
      beep_pin_oe_out && beep_pin_out == $past(main_div_q))
    else $error("main clock not driven");
  a_beep_drive: assert property (
    (!halt_mode_in && ctrl_two_q.beep_sel != 2'b00) |=>
      beep_pin_oe_out && beep_pin_out == $past(beep_q))
    else $error("beep tone not driven");
  a_ss_pin: assert property (
    !ctrl_two_q.slave_select_source |=> spi_ss_n_out == $past(sync2_q[34]))
    else $error("slave select not from pin");

  c_nmi_fire:   cover property (nonmask_irq_out);
  c_beep_on:    cover property (beep_pin_oe_out && beep_pin_out);
  c_grp_irq:    cover property (|ext_irq_out);
  c_sense_lock: cover property (acc_wr && paddr_in == MIPC_OFF_CTRL_ONE && !top_level);
  c_aux_on:     cover property (aux_clock_pin_oe_out && aux_clock_pin_out);

endmodule // mipc_top

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import mipc_pkg::*;
  localparam int H2K = 4;
  localparam int H1K = 8;
  localparam int H500 = 16;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        halt = 1'b0, nmi_pin = 1'b0, aux_osc = 1'b0, ss_pin = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, pin = 32'hFFFFFFFF, rd;
  logic [31:0] pin_dir = 32'h00000000, pin_opt = 32'h01010111;
  logic [1:0]  lvl = 2'h0;
  logic        err;
  wire  [31:0] prdata;
  wire  [4:0]  ext_irq;
  wire         pready, pslverr, nmi_irq, ss_n, beep, beep_oe, aux, aux_oe, irq;
  int          fail_count = 0, n_checks = 0, ac = 0;
  logic [7:0]  bt [4] = '{8'h40, 8'h50, 8'h20, 8'h30};
  int          bh [4] = '{1, H2K, H1K, H500};

  always #10 clk = ~clk;
  always @(posedge clk) begin
    ac <= (ac == 9) ? 0 : ac + 1;
    if (ac == 9) aux_osc <= ~aux_osc;
  end

  mipc_top #(.BEEP_2K_HALF(H2K), .BEEP_1K_HALF(H1K), .BEEP_500_HALF(H500)) mipc_top_inst (
    .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_level_in(lvl), .halt_mode_in(halt),
    .pin_in(pin), .pin_dir_in(pin_dir), .pin_opt_in(pin_opt),
    .nonmask_pin_in(nmi_pin), .aux_osc_in(aux_osc), .ss_n_pin_in(ss_pin),
    .ext_irq_out(ext_irq), .nonmask_irq_out(nmi_irq), .spi_ss_n_out(ss_n),
    .beep_pin_out(beep), .beep_pin_oe_out(beep_oe), .aux_clock_pin_out(aux),
    .aux_clock_pin_oe_out(aux_oe), .irq_out(irq));

  task automatic final_report;
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      final_report;
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(nm, e, rd);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Cycles between two successive changes of the beep pin
  task automatic half(output int h);
    logic v;
    int   n;
    h = 0;
    n = 0;
    v = beep;
    while (beep === v && n < 100) begin @(posedge clk); n++; end
    v = beep;
    while (beep === v && h < 100) begin @(posedge clk); h++; end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report;
  end

  initial begin
    int         h, t, k;
    logic       v;
    logic [1:0] cv, bv;
    logic [5:0] fe, re, rm;
    logic [4:0] seen;
    cyc(3);
    rst_n <= 1'b1;
    cyc(1);
    rdc("ctrl_one", MIPC_OFF_CTRL_ONE, 32'h00000000);
    rdc("ctrl_two", MIPC_OFF_CTRL_TWO, 32'h00000000);
    rdc("status", MIPC_OFF_STATUS, 32'h00000000);
    wr(MIPC_OFF_CTRL_ONE, 32'h000000FF);
    rdc("ctrl_one low prio", MIPC_OFF_CTRL_ONE, 32'h00000003);
    wr(MIPC_OFF_CTRL_ONE, 32'h00000000);
    rdc("edge while enabled", MIPC_OFF_CTRL_ONE, 32'h00000002);
    lvl <= 2'h3;
    wr(MIPC_OFF_CTRL_ONE, 32'h000000F0);
    rdc("ctrl_one top prio", MIPC_OFF_CTRL_ONE, 32'h000000F0);
    wr(MIPC_OFF_CTRL_TWO, 32'h000000FF);
    rdc("ctrl_two reserved", MIPC_OFF_CTRL_TWO, 32'h000000F3);
    apb(1'b0, 8'h10, 32'h00000000);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    for (k = 0; k < 4; k++) begin
      wr(MIPC_OFF_CTRL_TWO, {30'h0, k[1] ? 2'b00 : {1'b1, k[0]}});
      ss_pin <= k[1] ? k[0] : ~k[0];
      cyc(6);
      chk("slave select", {31'h0, k[0]}, {31'h0, ss_n});
    end
    wr(MIPC_OFF_ENABLE, 32'h0000003F);
    for (k = 0; k < 4; k++) begin
      cv = k[1:0];
      bv = 2'h3 - cv;
      rm = {1'b0, {2{cv[1], bv[1]}}, cv[1]};
      fe = {1'b0, {2{cv != 2'h2, bv != 2'h2}}, cv != 2'h2};
      re = fe | rm;
      wr(MIPC_OFF_CTRL_ONE, {24'h0, cv, bv, 4'h0});
      wr(MIPC_OFF_CLEAR, 32'h0000003F);
      pin <= pin & ~32'h01010111;
      seen = 5'h00;
      repeat (8) begin @(posedge clk); seen = seen | ext_irq; end
      chk("ext irq fall", {27'h0, fe[4:0]}, {27'h0, seen});
      rdc("status fall", MIPC_OFF_STATUS, {26'h0, fe});
      chk("irq level", {31'h0, |fe}, {31'h0, irq});
      pin <= pin | 32'h01010111;
      seen = 5'h00;
      repeat (8) begin @(posedge clk); seen = seen | ext_irq; end
      chk("ext irq rise", {27'h0, rm[4:0] | {{2{cv == 2'h0, bv == 2'h0}}, cv == 2'h0}},
          {27'h0, seen});
      rdc("status rise", MIPC_OFF_STATUS, {26'h0, re});
    end
    wr(MIPC_OFF_ENABLE, 32'h00000000);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(MIPC_OFF_ENABLE, 32'h0000003F);
    wr(MIPC_OFF_CLEAR, 32'h0000003F);
    rdc("status cleared", MIPC_OFF_STATUS, 32'h00000000);
    chk("irq cleared", 32'h0, {31'h0, irq});
    pin_dir <= 32'h00000111;
    pin_opt <= 32'h00000111;
    pin <= pin & ~32'h01010111;
    cyc(8);
    rdc("status gated pins", MIPC_OFF_STATUS, 32'h00000000);
    pin <= pin | 32'h01010111;
    cyc(8);
    pin_dir <= 32'h00000000;
    pin_opt <= 32'h01010111;
    wr(MIPC_OFF_CTRL_ONE, 32'h00000002);
    wr(MIPC_OFF_CTRL_ONE, 32'h00000003);
    nmi_pin <= 1'b1;
    t = 0;
    while (nmi_irq !== 1'b1 && t < 10) begin @(posedge clk); t++; end
    chk("nonmask pulse", 32'h1, {31'h0, t < 10});
    rdc("nonmask status", MIPC_OFF_STATUS, 32'h00000020);
    wr(MIPC_OFF_CLEAR, 32'h00000020);
    nmi_pin <= 1'b0;
    cyc(8);
    rdc("nonmask falling", MIPC_OFF_STATUS, 32'h00000000);
    wr(MIPC_OFF_CTRL_ONE, 32'h00000000);
    wr(MIPC_OFF_CTRL_ONE, 32'h00000001);
    rdc("edge after disable", MIPC_OFF_CTRL_ONE, 32'h00000001);
    nmi_pin <= 1'b1;
    cyc(8);
    rdc("nonmask rise ignored", MIPC_OFF_STATUS, 32'h00000000);
    nmi_pin <= 1'b0;
    cyc(8);
    rdc("nonmask fall", MIPC_OFF_STATUS, 32'h00000020);
    for (k = 0; k < 4; k++) begin
      wr(MIPC_OFF_CTRL_TWO, {24'h0, bt[k]});
      half(h);
      chk("beep enable", 32'h1, {31'h0, beep_oe});
      chk("beep half", bh[k], h);
    end
    halt <= 1'b1;
    cyc(4);
    chk("beep halted", 32'h0, {31'h0, beep_oe});
    halt <= 1'b0;
    wr(MIPC_OFF_CTRL_TWO, 32'h00000080);
    cyc(5);
    chk("aux enable", 32'h1, {31'h0, aux_oe});
    t = 0;
    v = aux;
    repeat (200) begin
      @(posedge clk);
      if (aux !== v) t++;
      v = aux;
    end
    chk("aux toggles", 32'h1, {31'h0, t >= 9 && t <= 11});
    halt <= 1'b1;
    cyc(4);
    chk("aux halted", 32'h0, {31'h0, aux_oe});
    final_report;
  end
endmodule // tb
